// ---- include/touch_serial_pkg.sv ----
// constants for the touch controller serial protocol block
package touch_serial_pkg;
	localparam int CLK_HZ         = 200000000;
	localparam int BAUD_RATE      = 38400;
	localparam int BAUD_DIV       = CLK_HZ / BAUD_RATE;
	localparam int CNT_W          = 13;
	localparam logic [7:0] CMD_CLOCK_READ = 8'hB0;
	localparam logic [7:0] CMD_CAL_COUNT  = 8'hB3;
	localparam logic [7:0] CMD_FOCUS      = 8'hB8;
	localparam logic [7:0] CMD_SAMPLES    = 8'hBA;
	localparam logic [7:0] CMD_COMM_MODE  = 8'hBB;
	localparam logic [7:0] CMD_MAX_DELTA  = 8'hBC;
	localparam logic [7:0] CMD_MIN_PRESS  = 8'hBE;
	localparam logic [7:0] CMD_FILTER     = 8'hA0;
	localparam logic [7:0] CMD_SELF_PD    = 8'hA2;
	localparam logic [7:0] CMD_ECHO       = 8'hA3;
	localparam logic [7:0] CMD_PRESSURE   = 8'hA4;
	localparam logic [7:0] CMD_CAL_CHECK  = 8'hA5;
	localparam logic [7:0] CMD_WAKEUP     = 8'hA7;
	localparam logic [7:0] CMD_SHUTDOWN   = 8'hA8;
	localparam logic [7:0] ACK_BYTE       = 8'hCA;
	localparam logic [7:0] HDR_SHORT      = 8'h80;
	localparam logic [7:0] HDR_LONG       = 8'h90;
	localparam int CMD_BIT        = 7;
	localparam int DATA_BITS      = 8;
	localparam int SHORT_LEN      = 4;
	localparam int LONG_LEN       = 5;
	localparam int STRAP_WAIT     = 3;
	localparam logic       RST_FILTER    = 1'b0;
	localparam logic       RST_SELF_PD   = 1'b0;
	localparam logic       RST_ECHO      = 1'b0;
	localparam logic       RST_PRESSURE  = 1'b1;
	localparam logic       RST_CAL_CHECK = 1'b0;
	localparam logic [5:0] RST_FOCUS     = 6'h00;
	localparam logic [5:0] RST_SAMPLES   = 6'h01;
	localparam logic [2:0] RST_COMM_MODE = 3'h1;
	localparam logic [5:0] RST_MAX_DELTA = 6'h00;
	localparam logic [6:0] RST_MIN_PRESS = 7'h00;
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_REPLY,
		SEQ_PACKET
	} seq_type;
endpackage

// ---- logic/two_entry_buffer.sv ----
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ps
module two_entry_buffer (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       inValid,
	input  wire logic [7:0] inData,
	output logic            inReady,
	output logic            outValid,
	output logic [7:0]      outData,
	input  wire logic       outReady
);
	typedef struct packed {
		logic [7:0] slot0;
		logic [7:0] slot1;
		logic [1:0] count;
	} buf_state_type;

	buf_state_type state_ff;
	buf_state_type nxt_state;
	logic          doPush;
	logic          doPop;

	assign inReady  = (state_ff.count != 2'h2);
	assign outValid = (state_ff.count != 2'h0);
	assign outData  = state_ff.slot0;
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	always_comb begin
		nxt_state = state_ff;
		if (doPop) begin
			nxt_state.slot0 = state_ff.slot1;
		end
		if (doPush) begin
			if (state_ff.count == 2'h0 || (doPop && state_ff.count == 2'h1)) begin
				nxt_state.slot0 = inData;
			end else begin
				nxt_state.slot1 = inData;
			end
		end
		nxt_state.count = state_ff.count + {1'b0, doPush} - {1'b0, doPop};
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end
endmodule

// ---- logic/touch_serial_protocol.sv ----
// serial command interpreter and packet sender of the touch controller
`timescale 1ns/1ps
//
// Function
// - link runs 38400 baud, eight data bits, no parity, one stop bit.
// - transmit and receive pins use inverted polarity.
// - top bit set marks a command; data bytes have it cleared.
// - every command gets an acknowledge, plus reply data where defined.
// - packets are five bytes with pressure on, four bytes otherwise.
// - header byte has bit 7 set, bit 4 marks five-byte packet.
// - second byte bit 6 is touch state, cleared on liftoff.
// - X and Y ten bits split over bytes two to four.
// - fifth byte carries seven-bit pressure, omitted when pressure off.
// - filter command toggles routing through the external filter path.
// - low shutdown pin forces power save, overriding internal setting.
// - indicator low in normal operation, high in power save.
// - terminal-ready high means host not ready, low means ready.
// - frequency select sampled once at power up; high means 10 MHz.
// - low reset pin resets; it must be held high otherwise.
// - settings reload fixed defaults on reset; calibration count taken from the calCount input.
// - power save entered automatically when enabled, or by shutdown pin.
// - clock-speed read answers acknowledge then 0 or 1.
// - calibration-count read answers acknowledge then 0, 2, 5 or 13.
module touch_serial_protocol #(
	parameter int BAUD_DIV = touch_serial_pkg::BAUD_DIV
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       rxPin,
	output logic            txPin,
	input  wire logic       termReadyPin,
	input  wire logic       shutdownPin,
	input  wire logic       clkSelPin,
	output logic            power_save_indicator,
	input  wire logic       coordValid,
	input  wire logic [9:0] coordX,
	input  wire logic [9:0] coordY,
	input  wire logic [6:0] coordZ,
	input  wire logic       touchState,
	output logic            coordReady,
	input  wire logic       idleTimeout,
	input  wire logic [7:0] calCount,
	output logic            filterEnable,
	output logic            selfPowerDownEnable,
	output logic            echoEnable,
	output logic            pressureEnable,
	output logic            calCheckEnable,
	output logic [5:0]      focusValue,
	output logic [5:0]      sampleCount,
	output logic [2:0]      commMode,
	output logic [5:0]      maxDelta,
	output logic [6:0]      minPressure,
	output logic            fastClock
);
	typedef struct packed {
		logic                                 rxS1;
		logic                                 rxS2;
		logic                                 shdS1;
		logic                                 shdS2;
		logic                                 dtrS1;
		logic                                 dtrS2;
		logic                                 selS1;
		logic                                 selS2;
		logic [1:0]                           strapWait;
		logic                                 fast;
		logic                                 rxBusy;
		logic [touch_serial_pkg::CNT_W-1:0]   rxCnt;
		logic [3:0]                           rxIdx;
		logic [7:0]                           rxShift;
		logic                                 expectData;
		logic [7:0]                           pendCmd;
		logic                                 repPend;
		logic                                 repHasData;
		logic [7:0]                           repData;
		touch_serial_pkg::seq_type            seq;
		logic [2:0]                           seqIdx;
		logic                                 seqHasData;
		logic [7:0]                           seqData;
		logic [9:0]                           pktX;
		logic [9:0]                           pktY;
		logic [6:0]                           pktZ;
		logic                                 pktS;
		logic                                 pktLong;
		logic                                 coordRdy;
		logic                                 filter;
		logic                                 selfPd;
		logic                                 echo;
		logic                                 press;
		logic                                 calChk;
		logic [5:0]                           focus;
		logic [5:0]                           samples;
		logic [2:0]                           mode;
		logic [5:0]                           delta;
		logic [6:0]                           minP;
		logic                                 powerSave;
		logic                                 txBusy;
		logic [touch_serial_pkg::CNT_W-1:0]   txCnt;
		logic [3:0]                           txIdx;
		logic [9:0]                           txShift;
		logic                                 txLine;
	} proto_state_type;

	localparam logic [touch_serial_pkg::CNT_W-1:0] BIT_CNT =
		touch_serial_pkg::CNT_W'(BAUD_DIV - 1);
	localparam logic [touch_serial_pkg::CNT_W-1:0] HALF_CNT =
		touch_serial_pkg::CNT_W'(BAUD_DIV / 2);

	proto_state_type state_ff;
	proto_state_type nxt_state;
	logic            bufInValid;
	logic [7:0]      bufInData;
	logic            bufInReady;
	logic            bufOutValid;
	logic [7:0]      bufOutData;
	logic            bufOutReady;
	logic            rxDone;
	logic [7:0]      rxByte;
	logic            seqLast;

	// packet byte by index
	function automatic logic [7:0] packetByte(
		input logic [2:0] idx,
		input logic       isLong,
		input logic       s,
		input logic [9:0] x,
		input logic [9:0] y,
		input logic [6:0] z
	);
		logic [7:0] b;
		b = 8'h00;
		case (idx)
			3'h0: b = isLong ? touch_serial_pkg::HDR_LONG
				: touch_serial_pkg::HDR_SHORT;
			3'h1: b = {1'b0, s, x[2:0], y[2:0]};
			3'h2: b = {1'b0, x[9:3]};
			3'h3: b = {1'b0, y[9:3]};
			3'h4: b = {1'b0, z};
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	// toggle reply data byte
	function automatic logic [7:0] flagByte(input logic v);
		return {7'h00, v};
	endfunction

	// commands that carry a data byte
	function automatic logic takesData(input logic [7:0] c);
		return (c == touch_serial_pkg::CMD_FOCUS) ||
			(c == touch_serial_pkg::CMD_SAMPLES) ||
			(c == touch_serial_pkg::CMD_COMM_MODE) ||
			(c == touch_serial_pkg::CMD_MAX_DELTA) ||
			(c == touch_serial_pkg::CMD_MIN_PRESS);
	endfunction

	assign rxDone = state_ff.rxBusy && state_ff.rxCnt == '0 &&
		state_ff.rxIdx == 4'(touch_serial_pkg::DATA_BITS + 1);
	assign rxByte = state_ff.rxShift;
	assign seqLast = (state_ff.seq == touch_serial_pkg::SEQ_REPLY) ?
		(state_ff.seqIdx == 3'h1 || !state_ff.seqHasData) :
		(state_ff.seqIdx == (state_ff.pktLong ?
		3'(touch_serial_pkg::LONG_LEN - 1) :
		3'(touch_serial_pkg::SHORT_LEN - 1)));

	always_comb begin
		bufInValid = 1'b0;
		bufInData  = 8'h00;
		case (state_ff.seq)
			touch_serial_pkg::SEQ_REPLY: begin
				bufInValid = 1'b1;
				bufInData  = (state_ff.seqIdx == 3'h0) ?
					touch_serial_pkg::ACK_BYTE : state_ff.seqData;
			end
			touch_serial_pkg::SEQ_PACKET: begin
				bufInValid = 1'b1;
				bufInData  = packetByte(state_ff.seqIdx, state_ff.pktLong,
					state_ff.pktS, state_ff.pktX, state_ff.pktY,
					state_ff.pktZ);
			end
			default: begin
				bufInValid = 1'b0;
			end
		endcase
	end

	assign bufOutReady = !state_ff.txBusy && !state_ff.dtrS2;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.rxS1  = rxPin;
		nxt_state.rxS2  = state_ff.rxS1;
		nxt_state.shdS1 = shutdownPin;
		nxt_state.shdS2 = state_ff.shdS1;
		nxt_state.dtrS1 = termReadyPin;
		nxt_state.dtrS2 = state_ff.dtrS1;
		nxt_state.selS1 = clkSelPin;
		nxt_state.selS2 = state_ff.selS1;
		if (state_ff.strapWait != 2'(touch_serial_pkg::STRAP_WAIT)) begin
			nxt_state.strapWait = state_ff.strapWait + 2'h1;
			if (state_ff.strapWait == 2'(touch_serial_pkg::STRAP_WAIT - 1)) begin
				nxt_state.fast = state_ff.selS2;
			end
		end
		if (!state_ff.rxBusy) begin
			if (state_ff.rxS2) begin
				nxt_state.rxBusy = 1'b1;
				nxt_state.rxCnt  = HALF_CNT;
				nxt_state.rxIdx  = 4'h0;
			end
		end else if (state_ff.rxCnt != '0) begin
			nxt_state.rxCnt = state_ff.rxCnt - 1'b1;
		end else begin
			nxt_state.rxCnt = BIT_CNT;
			nxt_state.rxIdx = state_ff.rxIdx + 4'h1;
			if (state_ff.rxIdx == 4'h0 && !state_ff.rxS2) begin
				nxt_state.rxBusy = 1'b0;
			end else if (state_ff.rxIdx <= 4'(touch_serial_pkg::DATA_BITS)) begin
				nxt_state.rxShift = {~state_ff.rxS2, state_ff.rxShift[7:1]};
				if (state_ff.rxIdx == 4'h0) begin
					nxt_state.rxShift = state_ff.rxShift;
				end
			end else begin
				nxt_state.rxBusy = 1'b0;
			end
		end
		// command parser
		if (rxDone) begin
			nxt_state.powerSave = 1'b0;
			// command byte recognised by top bit
			if (rxByte[touch_serial_pkg::CMD_BIT]) begin
				nxt_state.expectData = takesData(rxByte);
				nxt_state.pendCmd    = rxByte;
				if (!takesData(rxByte)) begin
					nxt_state.repPend    = 1'b1;
					nxt_state.repHasData = 1'b0;
					case (rxByte)
						touch_serial_pkg::CMD_CLOCK_READ: begin
							nxt_state.repHasData = 1'b1;
							nxt_state.repData    = flagByte(state_ff.fast);
						end
						touch_serial_pkg::CMD_CAL_COUNT: begin
							nxt_state.repHasData = 1'b1;
							nxt_state.repData    = calCount;
						end
						touch_serial_pkg::CMD_FILTER: begin
							nxt_state.filter     = !state_ff.filter;
							nxt_state.repHasData = 1'b1;
							nxt_state.repData    = flagByte(!state_ff.filter);
						end
						touch_serial_pkg::CMD_SELF_PD: begin
							nxt_state.selfPd     = !state_ff.selfPd;
							nxt_state.repHasData = 1'b1;
							nxt_state.repData    = flagByte(!state_ff.selfPd);
						end
						touch_serial_pkg::CMD_ECHO: begin
							nxt_state.echo       = !state_ff.echo;
							nxt_state.repHasData = 1'b1;
							nxt_state.repData    = flagByte(!state_ff.echo);
						end
						touch_serial_pkg::CMD_PRESSURE: begin
							nxt_state.press      = !state_ff.press;
							nxt_state.repHasData = 1'b1;
							nxt_state.repData    = flagByte(!state_ff.press);
						end
						touch_serial_pkg::CMD_CAL_CHECK: begin
							nxt_state.calChk     = !state_ff.calChk;
							nxt_state.repHasData = 1'b1;
							nxt_state.repData    = flagByte(!state_ff.calChk);
						end
						touch_serial_pkg::CMD_SHUTDOWN: begin
							nxt_state.powerSave = 1'b1;
						end
						default: begin
							nxt_state.repHasData = 1'b0;
						end
					endcase
				end
			end else if (state_ff.expectData) begin
				nxt_state.expectData = 1'b0;
				nxt_state.repPend    = 1'b1;
				nxt_state.repHasData = 1'b1;
				nxt_state.repData    = rxByte;
				case (state_ff.pendCmd)
					touch_serial_pkg::CMD_FOCUS:     nxt_state.focus   = rxByte[5:0];
					touch_serial_pkg::CMD_SAMPLES:   nxt_state.samples = rxByte[5:0];
					touch_serial_pkg::CMD_COMM_MODE: nxt_state.mode    = rxByte[2:0];
					touch_serial_pkg::CMD_MAX_DELTA: nxt_state.delta   = rxByte[5:0];
					touch_serial_pkg::CMD_MIN_PRESS: nxt_state.minP    = rxByte[6:0];
					default: nxt_state.repHasData = 1'b1;
				endcase
			end
		end
		if (idleTimeout && state_ff.selfPd) begin
			nxt_state.powerSave = 1'b1;
		end else if (coordValid && state_ff.powerSave) begin
			nxt_state.powerSave = 1'b0;
		end
		if (!state_ff.shdS2) begin
			nxt_state.powerSave = 1'b1;
		end
		// byte sequencer
		case (state_ff.seq)
			touch_serial_pkg::SEQ_IDLE: begin
				if (state_ff.repPend) begin
					nxt_state.seq        = touch_serial_pkg::SEQ_REPLY;
					nxt_state.seqIdx     = 3'h0;
					nxt_state.seqHasData = state_ff.repHasData;
					nxt_state.seqData    = state_ff.repData;
					nxt_state.repPend    = rxDone && nxt_state.repPend;
				end else if (coordValid && state_ff.coordRdy) begin
					nxt_state.seq     = touch_serial_pkg::SEQ_PACKET;
					nxt_state.seqIdx  = 3'h0;
					nxt_state.pktLong = state_ff.press;
					nxt_state.pktX    = coordX;
					nxt_state.pktY    = coordY;
					nxt_state.pktZ    = coordZ;
					nxt_state.pktS    = touchState;
				end
			end
			touch_serial_pkg::SEQ_REPLY, touch_serial_pkg::SEQ_PACKET: begin
				if (bufInReady) begin
					nxt_state.seqIdx = state_ff.seqIdx + 3'h1;
					if (seqLast) begin
						nxt_state.seq = touch_serial_pkg::SEQ_IDLE;
					end
				end
			end
			default: begin
				nxt_state.seq = touch_serial_pkg::SEQ_IDLE;
			end
		endcase
		nxt_state.coordRdy = (nxt_state.seq == touch_serial_pkg::SEQ_IDLE) &&
			!nxt_state.repPend && !nxt_state.powerSave;
		if (!state_ff.txBusy) begin
			nxt_state.txLine = 1'b0;
			if (bufOutValid && bufOutReady) begin
				nxt_state.txBusy  = 1'b1;
				nxt_state.txShift = {1'b1, bufOutData, 1'b0};
				nxt_state.txCnt   = BIT_CNT;
				nxt_state.txIdx   = 4'h0;
				nxt_state.txLine  = 1'b1;
			end
		end else if (state_ff.txCnt != '0) begin
			nxt_state.txCnt = state_ff.txCnt - 1'b1;
		end else if (state_ff.txIdx == 4'(touch_serial_pkg::DATA_BITS + 1)) begin
			nxt_state.txBusy = 1'b0;
			nxt_state.txLine = 1'b0;
		end else begin
			nxt_state.txCnt   = BIT_CNT;
			nxt_state.txIdx   = state_ff.txIdx + 4'h1;
			nxt_state.txShift = {1'b1, state_ff.txShift[9:1]};
			nxt_state.txLine  = !state_ff.txShift[1];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff           <= '0;
			state_ff.rxS1      <= 1'b0;
			state_ff.shdS1     <= 1'b1;
			state_ff.shdS2     <= 1'b1;
			state_ff.fast      <= 1'b1;
			state_ff.filter    <= touch_serial_pkg::RST_FILTER;
			state_ff.selfPd    <= touch_serial_pkg::RST_SELF_PD;
			state_ff.echo      <= touch_serial_pkg::RST_ECHO;
			state_ff.press     <= touch_serial_pkg::RST_PRESSURE;
			state_ff.calChk    <= touch_serial_pkg::RST_CAL_CHECK;
			state_ff.focus     <= touch_serial_pkg::RST_FOCUS;
			state_ff.samples   <= touch_serial_pkg::RST_SAMPLES;
			state_ff.mode      <= touch_serial_pkg::RST_COMM_MODE;
			state_ff.delta     <= touch_serial_pkg::RST_MAX_DELTA;
			state_ff.minP      <= touch_serial_pkg::RST_MIN_PRESS;
			state_ff.seq       <= touch_serial_pkg::SEQ_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	two_entry_buffer txBuffer (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.inValid  (bufInValid),
		.inData   (bufInData),
		.inReady  (bufInReady),
		.outValid (bufOutValid),
		.outData  (bufOutData),
		.outReady (bufOutReady)
	);

	assign txPin                = state_ff.txLine;
	assign power_save_indicator = state_ff.powerSave;
	assign coordReady           = state_ff.coordRdy;
	assign filterEnable         = state_ff.filter;
	assign selfPowerDownEnable  = state_ff.selfPd;
	assign echoEnable           = state_ff.echo;
	assign pressureEnable       = state_ff.press;
	assign calCheckEnable       = state_ff.calChk;
	assign focusValue           = state_ff.focus;
	assign sampleCount          = state_ff.samples;
	assign commMode             = state_ff.mode;
	assign maxDelta             = state_ff.delta;
	assign minPressure          = state_ff.minP;
	assign fastClock            = state_ff.fast;
endmodule

// ---- verif/touch_serial_assertions.sv ----
// assertion checker for the touch serial protocol block
`timescale 1ns/1ps
module touch_serial_assertions #(
	parameter int BAUD_DIV = touch_serial_pkg::BAUD_DIV
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic txPin,
	input wire logic shutdownPin,
	input wire logic power_save_indicator,
	input wire logic coordValid,
	input wire logic coordReady,
	input wire logic filterEnable,
	input wire logic selfPowerDownEnable,
	input wire logic pressureEnable,
	input wire logic fastClock
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic [3:0] upCnt_ff;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			upCnt_ff <= 4'h0;
		else if (upCnt_ff != 4'hF)
			upCnt_ff <= upCnt_ff + 4'h1;
	end
	sequence s_shutLow; !shutdownPin [*5]; endsequence
	sequence s_take; coordValid && coordReady; endsequence
	property p_txHigh; $rose(txPin) |=> txPin [*8]; endproperty
	property p_txLow; $fell(txPin) |=> !txPin [*8]; endproperty
	property p_shutForce; s_shutLow |-> power_save_indicator; endproperty
	property p_shutBlock; s_shutLow |-> !coordReady; endproperty
	property p_saveReady;
		power_save_indicator |-> ##[0:1] !coordReady;
	endproperty
	property p_take; s_take |=> !coordReady [*8]; endproperty
	property p_strap; upCnt_ff > 4'h5 |-> $stable(fastClock); endproperty
	property p_filter;
		$changed(filterEnable) |->
			$stable(selfPowerDownEnable) && $stable(pressureEnable);
	endproperty
	a_txHigh: assert property (p_txHigh)
		else $error("tx high stretch shorter than a bit");
	a_txLow: assert property (p_txLow)
		else $error("tx low stretch shorter than a bit");
	a_shutForce: assert property (p_shutForce)
		else $error("shutdown pin low without power save");
	a_shutBlock: assert property (p_shutBlock)
		else $error("packets accepted during shutdown");
	a_saveReady: assert property (p_saveReady)
		else $error("ready while indicator shows power save");
	a_take: assert property (p_take)
		else $error("ready again too soon after packet take");
	a_strap: assert property (p_strap)
		else $error("clock select changed after start up");
	a_filter: assert property (p_filter)
		else $error("filter toggle disturbed other settings");
endmodule
bind touch_serial_protocol touch_serial_assertions #(
	.BAUD_DIV(BAUD_DIV)
) chk (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.txPin(txPin),
	.shutdownPin(shutdownPin),
	.power_save_indicator(power_save_indicator),
	.coordValid(coordValid),
	.coordReady(coordReady),
	.filterEnable(filterEnable),
	.selfPowerDownEnable(selfPowerDownEnable),
	.pressureEnable(pressureEnable),
	.fastClock(fastClock)
);

// ---- verif/host_serial_model.sv ----
// host side model: inverted serial sender and receiver
`timescale 1ns/1ps
module host_serial_model #(
	parameter int BIT = 16
) (
	input  wire logic sys_clk,
	input  wire logic txPin,
	output logic      rxPin,
	output logic      termReadyPin
);
	logic [7:0] rxq [$];
	logic [7:0] rxd;
	initial begin
		rxPin = 1'b0;
		termReadyPin = 1'b0;
	end
	task set_busy(input logic b);
		@(posedge sys_clk);
		termReadyPin <= b;
	endtask
	task send(input logic [7:0] b);
		@(posedge sys_clk);
		rxPin <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge sys_clk);
			rxPin <= ~b[i];
		end
		repeat (BIT) @(posedge sys_clk);
		rxPin <= 1'b0;
		repeat (BIT) @(posedge sys_clk);
	endtask
	always begin
		@(posedge sys_clk);
		if (txPin === 1'b1) begin
			repeat (BIT / 2) @(posedge sys_clk);
			for (int k = 0; k < 8; k++) begin
				repeat (BIT) @(posedge sys_clk);
				rxd[k] = ~txPin;
			end
			repeat (BIT) @(posedge sys_clk);
			rxq.push_back(rxd);
		end
	end
endmodule

// ---- verif/touch_serial_protocol_tb_top.sv ----
// testbench for the touch serial protocol block
`timescale 1ns/1ps
module touch_serial_protocol_tb_top;
	localparam int BIT = 16;
	localparam int LIMIT = 60000;
	localparam logic [39:0] TOGS = 40'hA0A2A3A4A5;
	localparam logic [39:0] DCMD = 40'hB8BABBBCBE;
	localparam logic [39:0] DVAL = 40'h3F2004157F;
	logic       sys_clk, rst_n, rxPin, txPin, termReadyPin;
	logic       shutdownPin, coordValid, coordReady, touchState;
	logic       idleTimeout, psi, fastClock;
	logic [9:0] coordX, coordY;
	logic [6:0] coordZ, minPressure;
	logic [5:0] focusValue, sampleCount, maxDelta;
	logic [2:0] commMode;
	logic [4:0] tog;
	logic       clkSel, filterEn, selfPdEn, echoEn, pressEn, calChkEn;
	logic [7:0] calCnt;
	int         fails, n_tests, cyc;
	touch_serial_protocol #(.BAUD_DIV(BIT)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .rxPin(rxPin), .txPin(txPin),
		.termReadyPin(termReadyPin), .shutdownPin(shutdownPin),
		.clkSelPin(clkSel), .power_save_indicator(psi),
		.coordValid(coordValid), .coordX(coordX), .coordY(coordY),
		.coordZ(coordZ), .touchState(touchState),
		.coordReady(coordReady), .idleTimeout(idleTimeout),
		.calCount(calCnt), .filterEnable(filterEn),
		.selfPowerDownEnable(selfPdEn), .echoEnable(echoEn),
		.pressureEnable(pressEn), .calCheckEnable(calChkEn),
		.focusValue(focusValue), .sampleCount(sampleCount),
		.commMode(commMode), .maxDelta(maxDelta),
		.minPressure(minPressure), .fastClock(fastClock)
	);
	assign tog = {filterEn, selfPdEn, echoEn, pressEn, calChkEn};
	host_serial_model #(.BIT(BIT)) host (
		.sys_clk(sys_clk), .txPin(txPin), .rxPin(rxPin),
		.termReadyPin(termReadyPin)
	);
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task getb(input logic [7:0] exp);
		logic [7:0] got;
		got = 8'hXX;
		for (int i = 0; i < 3000 && host.rxq.size() == 0; i++)
			@(posedge sys_clk);
		if (host.rxq.size() != 0)
			got = host.rxq.pop_front();
		chk(got, exp);
	endtask
	task t_packet(input logic s, input logic [9:0] x, y,
		input logic [6:0] z);
		logic lng;
		lng = tog[1];
		@(posedge sys_clk);
		coordX <= x;
		coordY <= y;
		coordZ <= z;
		touchState <= s;
		coordValid <= 1'b1;
		for (int i = 0; i < 200; i++) begin
			@(posedge sys_clk);
			if (coordReady === 1'b1)
				break;
		end
		coordValid <= 1'b0;
		getb(lng ? 8'h90 : 8'h80);
		getb({1'b0, s, x[2:0], y[2:0]});
		getb({1'b0, x[9:3]});
		getb({1'b0, y[9:3]});
		if (lng)
			getb({1'b0, z});
		repeat (400) @(posedge sys_clk);
		chk(8'(host.rxq.size()), 8'h00);
	endtask
	task t_toggles;
		logic [4:0] e;
		e = 5'h02;
		chk({3'h0, tog}, 8'h02);
		for (int i = 0; i < 5; i++) begin
			e = e ^ (5'h10 >> i);
			host.send(TOGS[39 - 8 * i -: 8]);
			getb(8'hCA);
			getb({7'h0, e[4 - i]});
			chk({3'h0, tog}, {3'h0, e});
		end
	endtask
	task t_data;
		host.send(8'h55);
		for (int i = 0; i < 5; i++) begin
			host.send(DCMD[39 - 8 * i -: 8]);
			host.send(DVAL[39 - 8 * i -: 8]);
			getb(8'hCA);
			getb(DVAL[39 - 8 * i -: 8]);
		end
		chk({2'h0, focusValue}, 8'h3F);
		chk({2'h0, sampleCount}, 8'h20);
		chk({5'h0, commMode}, 8'h04);
		chk({2'h0, maxDelta}, 8'h15);
		chk({1'h0, minPressure}, 8'h7F);
	endtask
	task t_reads;
		host.set_busy(1'b1);
		host.send(8'hB0);
		repeat (400) @(posedge sys_clk);
		chk(8'(host.rxq.size()), 8'h00);
		host.set_busy(1'b0);
		getb(8'hCA);
		getb(8'h01);
		chk({7'h0, fastClock}, 8'h01);
		host.send(8'hB3);
		getb(8'hCA);
		getb(8'h0D);
	endtask
	task wake;
		host.send(8'hA7);
		getb(8'hCA);
		repeat (50) @(posedge sys_clk);
		chk({7'h0, psi}, 8'h00);
	endtask
	task t_power;
		shutdownPin <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk({6'h0, psi, coordReady}, 8'h02);
		shutdownPin <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk({6'h0, psi, coordReady}, 8'h02);
		wake;
		host.send(8'hA8);
		getb(8'hCA);
		repeat (8) @(posedge sys_clk);
		chk({7'h0, psi}, 8'h01);
		wake;
		idleTimeout <= 1'b1;
		@(posedge sys_clk);
		idleTimeout <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk({7'h0, psi}, 8'h01);
		wake;
	endtask
	task t_strap;
		clkSel <= 1'b0;
		calCnt <= 8'h05;
		rst_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk({3'h0, tog}, 8'h02);
		chk({6'h0, psi, coordReady}, 8'h01);
		chk({7'h0, fastClock}, 8'h00);
		host.send(8'hB0);
		getb(8'hCA);
		getb(8'h00);
		host.send(8'hB3);
		getb(8'hCA);
		getb(8'h05);
	endtask
	task print_verdict;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			fails++;
			print_verdict;
		end
	end
	initial begin
		rst_n = 1'b0;
		shutdownPin = 1'b1;
		clkSel = 1'b1;
		calCnt = 8'h0D;
		coordValid = 1'b0;
		idleTimeout = 1'b0;
		touchState = 1'b0;
		coordX = 10'h000;
		coordY = 10'h000;
		coordZ = 7'h00;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
		t_packet(1'b1, 10'h2A5, 10'h15B, 7'h6C);
		t_toggles;
		t_packet(1'b0, 10'h3FF, 10'h001, 7'h7F);
		t_data;
		t_reads;
		t_power;
		t_strap;
		print_verdict;
	end
endmodule
